//--- rtl/cop_field_decode.sv
// Secondary decode of the three coprocessor opcode classes.
// Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
module cop_field_decode
  import cpu_decode_pkg::*;
(
  // Word and the coprocessor it addresses
  input wire logic [31:0] instr_word,
  input wire logic [1:0] cop_unit_sel,
  // Operation found and its legality marks
  output op_class_e sub_class,
  output logic [5:0] sub_index,
  output logic sub_rsv,
  output logic sub_hi64,
  output logic sub_partner,
  output logic sub_dbg,
  output logic sub_ase
);

  logic [4:0] rs; // Sub-class selector field
  logic [5:0] fn; // Function field
  logic tf; // Sense bit

  assign rs = instr_word[25:21];
  assign fn = instr_word[5:0];
  assign tf = instr_word[TF_BIT];

  // ----------------------------------------------------------------
  // Field tables
  // ----------------------------------------------------------------
  // Rows 10/11 of rs go to functions, row 01 branches, row 00 moves
  always_comb begin
    sub_class = CLS_COP_MOVE;
    sub_index = {1'b0, rs};
    sub_rsv = 1'b0;
    sub_hi64 = 1'b0;
    sub_partner = 1'b0;
    sub_dbg = 1'b0;
    sub_ase = 1'b0;
    if (rs[4]) begin
      // Function-decoded group
      case (cop_unit_sel)
        2'd0: begin
          sub_class = CLS_SYS_FN;
          sub_index = fn;
          sub_rsv = ~mask_bit(SYS_FN_VALID, fn);
          sub_dbg = (fn == FN_DBG_RET);
        end
        2'd1: begin
          sub_class = CLS_FP_FMT;
          sub_index = fn;
          if (rs[3]) begin
            sub_rsv = 1'b1; // Row 11 holds no format
          end else begin
            case (rs[2:0])
              FMT_SINGLE: begin
                sub_class = CLS_FP_SINGLE;
                sub_rsv = mask_bit(FPS_RSV, fn);
                sub_hi64 = mask_bit(FPS_HI64, fn);
                sub_ase = mask_bit(FPS_ASE, fn);
                if (fn == FN_MOVE_CF) begin
                  sub_class = CLS_COND_MOVE;
                  sub_index = {5'h00, tf};
                end
              end
              FMT_DOUBLE, FMT_WORD: begin
                sub_rsv = 1'b0; // Tables not decoded here
              end
              FMT_LONG, FMT_PAIRED: begin
                sub_hi64 = 1'b1;
              end
              default: begin
                sub_rsv = 1'b1;
              end
            endcase
          end
        end
        default: begin
          // User coprocessor owns its function space
          sub_class = CLS_COP_FN;
          sub_index = fn;
          sub_partner = 1'b1;
        end
      endcase
    end else if (rs[3]) begin
      // Branch row; any-of-two/four only on the float unit
      if ((cop_unit_sel != 2'd0) && ((rs[2:0] == 3'd0) ||
          ((cop_unit_sel == 2'd1) && (rs[2:1] == 2'b00 ||
          rs[2:0] == 3'd2)))) begin
        sub_class = CLS_COP_BRANCH;
        sub_index = {2'b00, rs[1:0], instr_word[LIKELY_BIT], tf};
        sub_ase = (rs[1:0] != 2'b00);
        sub_hi64 = (rs[1:0] != 2'b00);
      end else begin
        sub_rsv = 1'b1;
      end
    end else begin
      // Moves: doubleword forms are 64-bit only
      sub_hi64 = (rs[1:0] == 2'b01);
      if (cop_unit_sel == 2'd0) begin
        sub_rsv = rs[1];
      end else begin
        sub_rsv = (rs[1:0] == 2'b11);
      end
    end
  end

endmodule // cop_field_decode

//--- rtl/cpu_decode_pkg.sv
// Shared constants and types of the instruction decoder.
// Assumes a 32-bit APB slave on one clock; no other context.
package cpu_decode_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] INSTR_WORD_OFS = 8'h00;
  localparam logic [7:0] MODE_CTRL_OFS = 8'h04;
  localparam logic [7:0] VERDICT_OFS = 8'h08;
  localparam logic [7:0] FAULT_COUNT_OFS = 8'h0c;

  // Mode control fields and reset value
  localparam int MODE_KERNEL_BIT = 0;
  localparam int MODE_DEBUG_BIT = 1;
  localparam int MODE_EN64_BIT = 2;
  localparam int MODE_ASE_BIT = 3;
  localparam int MODE_DBGSUP_BIT = 4;
  localparam int MODE_CU_LSB = 8;
  localparam logic [11:0] MODE_RESET = 12'h000;

  // Verdict register fields
  localparam int VER_CLASS_LSB = 0;
  localparam int VER_INDEX_LSB = 4;
  localparam int VER_OK_BIT = 12;
  localparam int VER_RI_BIT = 13;
  localparam int VER_CPU_BIT = 14;
  localparam int VER_COP_LSB = 16;

  // Instruction field positions
  localparam int TF_BIT = 16;
  localparam int LIKELY_BIT = 17;

  // Primary and secondary codes that open a class
  localparam logic [5:0] OPC_FUNC = 6'h00;
  localparam logic [5:0] OPC_REG_IMMEDIATE_CLASS = 6'h01;
  localparam logic [5:0] OPC_SYS_COP = 6'h10;
  localparam logic [5:0] OPC_FPU = 6'h11;
  localparam logic [5:0] OPC_USER_COP = 6'h12;
  localparam logic [5:0] OPC_FPU_EXT = 6'h13;
  localparam logic [5:0] OPC_SECOND = 6'h1c;
  localparam logic [5:0] FN_COND_MOVE = 6'h01;
  localparam logic [5:0] FN_MOVE_CF = 6'h11;
  localparam logic [5:0] FN_DBG_RET = 6'h1f;
  localparam logic [5:0] FN_DBG_BREAK = 6'h3f;
  localparam logic [2:0] FMT_SINGLE = 3'h0;
  localparam logic [2:0] FMT_DOUBLE = 3'h1;
  localparam logic [2:0] FMT_WORD = 3'h4;
  localparam logic [2:0] FMT_LONG = 3'h5;
  localparam logic [2:0] FMT_PAIRED = 3'h6;

  // Table masks, one bit per code position
  localparam logic [63:0] PRI_RSV = 64'h0800_0000_8000_0000;
  localparam logic [63:0] PRI_HI64 = 64'h9090_3080_0f08_0000;
  localparam logic [63:0] PRI_ASE = 64'h0000_0000_6000_0000;
  localparam logic [63:0] PRI_PARTNER = 64'h4444_0000_0000_0000;
  localparam logic [63:0] FUNC_RSV = 64'h22a0_0300_0020_4020;
  localparam logic [63:0] FUNC_HI64 = 64'hdd00_f000_f0d0_0000;
  localparam logic [63:0] REG_IMMEDIATE_CLASS_RSV = 64'h0000_0000_fff0_a0f0;
  localparam logic [63:0] SECOND_PARTNER = 64'h7fff_ffcc_ffff_ffc8;
  localparam logic [63:0] SECOND_HI64 = 64'h0000_0030_0000_0000;
  localparam logic [63:0] SYS_FN_VALID = 64'h0000_0001_8100_0146;
  localparam logic [63:0] FPS_RSV = 64'h0000_ff8d_0f91_0000;
  localparam logic [63:0] FPS_HI64 = 64'h0000_0060_f060_0f00;
  localparam logic [63:0] FPS_ASE = 64'h0000_0000_f000_0000;

  // Which table finally named the operation
  typedef enum logic [3:0] {
    CLS_PRIMARY = 4'h0,
    CLS_FUNC = 4'h1,
    CLS_REG_IMMEDIATE_CLASS = 4'h2,
    CLS_SECOND = 4'h3,
    CLS_COND_MOVE = 4'h4,
    CLS_COP_MOVE = 4'h5,
    CLS_COP_BRANCH = 4'h6,
    CLS_COP_FN = 4'h7,
    CLS_SYS_FN = 4'h8,
    CLS_FP_SINGLE = 4'h9,
    CLS_FP_FMT = 4'ha,
    CLS_FP_EXT = 4'hb
  } op_class_e;

  // Table lookup shared by both decoders
  function automatic logic mask_bit(input logic [63:0] m,
                                    input logic [5:0] i);
    return m[i];
  endfunction

endpackage

//--- rtl/cpu_instruction_decoder.sv
// Instruction-word decoder with its verdict, reached over APB.
// Assumes an APB master on pclk; decode is timed by register writes.
`timescale 1ns/1ps
module cpu_instruction_decoder
  import cpu_decode_pkg::*;
#(
  parameter int ADDR_W = 8, // APB address width
  parameter int CNT_W = 16 // Width of each fault counter
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Verdict towards exception control
  output logic verdict_stb,
  output op_class_e op_class,
  output logic [5:0] op_index,
  output logic op_ok,
  output logic raise_ri,
  output logic raise_cpu,
  output logic [1:0] cop_unit
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] instr; // Word under decode
    logic [11:0] mode; // Privilege and feature state
    logic pend; // A decode is owed
    op_class_e cls; // Registered verdict
    logic [5:0] idx;
    logic ok;
    logic ri;
    logic cpu;
    logic [1:0] cop;
    logic vstb; // One-cycle verdict strobe
    logic [CNT_W-1:0] ri_cnt; // Reserved Instruction tally
    logic [CNT_W-1:0] cpu_cnt; // Coprocessor Unusable tally
    logic pready; // APB answer
    logic pslverr;
    logic [31:0] prdata;
  } dec_state_s;

  dec_state_s st_ff; // Registered state
  dec_state_s nxt_st; // Its next value

  // ----------------------------------------------------------------
  // Field views of the held word
  // ----------------------------------------------------------------
  logic [2:0] op_row; // Opcode row
  logic [2:0] op_col; // Opcode column
  logic [5:0] opc; // Whole primary opcode
  logic [5:0] fn; // Function field
  logic [4:0] rt; // rt field

  assign op_row = st_ff.instr[31:29];
  assign op_col = st_ff.instr[28:26];
  assign opc = {op_row, op_col};
  assign fn = st_ff.instr[5:0];
  assign rt = st_ff.instr[20:16];

  // Mode bits
  logic kernel, debug, en64, ase_en, dbg_sup;
  logic [3:0] cu; // Per-coprocessor usable bits

  assign kernel = st_ff.mode[MODE_KERNEL_BIT];
  assign debug = st_ff.mode[MODE_DEBUG_BIT];
  assign en64 = st_ff.mode[MODE_EN64_BIT];
  assign ase_en = st_ff.mode[MODE_ASE_BIT];
  assign dbg_sup = st_ff.mode[MODE_DBGSUP_BIT];
  assign cu = st_ff.mode[MODE_CU_LSB +: 4];

  // ----------------------------------------------------------------
  // Coprocessor secondary tables
  // ----------------------------------------------------------------
  op_class_e sub_class; // Result of the coprocessor tables
  logic [5:0] sub_index;
  logic sub_rsv, sub_hi64, sub_partner, sub_dbg, sub_ase;

  cop_field_decode u_cop (
    .instr_word(st_ff.instr),
    .cop_unit_sel(op_col[1:0]),
    .sub_class(sub_class),
    .sub_index(sub_index),
    .sub_rsv(sub_rsv),
    .sub_hi64(sub_hi64),
    .sub_partner(sub_partner),
    .sub_dbg(sub_dbg),
    .sub_ase(sub_ase)
  );

  // ----------------------------------------------------------------
  // Primary and function-field tables
  // ----------------------------------------------------------------
  op_class_e d_class; // Table outcome before legality
  logic [5:0] d_index;
  logic d_rsv, d_hi64, d_partner, d_dbg, d_ase;
  logic d_iscop; // Word addresses a coprocessor
  logic [1:0] d_cop; // Which one

  // Class codes never execute; they hand on to their own table
  always_comb begin
    d_class = CLS_PRIMARY;
    d_index = opc;
    d_rsv = mask_bit(PRI_RSV, opc);
    d_hi64 = mask_bit(PRI_HI64, opc);
    d_ase = mask_bit(PRI_ASE, opc);
    d_partner = mask_bit(PRI_PARTNER, opc);
    d_dbg = 1'b0;
    d_iscop = 1'b0;
    d_cop = 2'd0;
    // Coprocessor loads and stores
    if (op_row[2:1] == 2'b11 &&
        (op_col[1:0] == 2'b01 || op_col[1:0] == 2'b10)) begin
      d_iscop = 1'b1;
      d_cop = op_col[1:0];
    end
    case (opc)
      OPC_FUNC: begin
        d_class = CLS_FUNC;
        d_index = fn;
        d_rsv = mask_bit(FUNC_RSV, fn);
        d_hi64 = mask_bit(FUNC_HI64, fn);
        if (fn == FN_COND_MOVE) begin
          d_class = CLS_COND_MOVE;
          d_index = {5'h00, st_ff.instr[TF_BIT]};
          d_iscop = 1'b1;
          d_cop = 2'd1;
        end
      end
      OPC_REG_IMMEDIATE_CLASS: begin
        d_class = CLS_REG_IMMEDIATE_CLASS;
        d_index = {1'b0, rt};
        d_rsv = mask_bit(REG_IMMEDIATE_CLASS_RSV, {1'b0, rt});
      end
      OPC_SYS_COP, OPC_FPU, OPC_USER_COP: begin
        d_class = sub_class;
        d_index = sub_index;
        d_rsv = sub_rsv;
        d_hi64 = sub_hi64;
        d_partner = sub_partner;
        d_dbg = sub_dbg;
        d_ase = sub_ase;
        d_iscop = 1'b1;
        d_cop = op_col[1:0];
      end
      OPC_FPU_EXT: begin
        // Whole class is 64-bit only; its table stays open
        d_class = CLS_FP_EXT;
        d_index = fn;
        d_iscop = 1'b1;
        d_cop = 2'd1;
      end
      OPC_SECOND: begin
        d_class = CLS_SECOND;
        d_index = fn;
        d_partner = mask_bit(SECOND_PARTNER, fn);
        d_hi64 = mask_bit(SECOND_HI64, fn);
        d_dbg = (fn == FN_DBG_BREAK);
      end
      default: begin
        d_class = CLS_PRIMARY;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  logic cop_usable; // Addressed coprocessor may be used
  logic priv64; // 64-bit encodings allowed
  logic v_ok, v_ri, v_cpu; // Exactly one of these is set

  assign priv64 = kernel | debug | en64;

  // System coprocessor is always open to privileged code
  always_comb begin
    if (d_cop == 2'd0) begin
      cop_usable = kernel | debug | cu[0];
    end else begin
      cop_usable = cu[d_cop];
    end
  end

  // Unusable coprocessor outranks every other cause
  always_comb begin
    v_ok = 1'b0;
    v_ri = 1'b0;
    v_cpu = 1'b0;
    if (d_iscop && !cop_usable) begin
      v_cpu = 1'b1;
    end else if (d_rsv || d_partner) begin
      v_ri = 1'b1;
    end else if (d_dbg && !dbg_sup) begin
      v_ri = 1'b1;
    end else if (d_ase && !ase_en) begin
      v_ri = 1'b1;
    end else if (d_hi64 && !priv64) begin
      v_ri = 1'b1;
    end else begin
      v_ok = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus and state update
  // ----------------------------------------------------------------
  logic acc_start; // Access phase, answer not yet given
  logic acc_done; // Edge at which the master takes the answer
  logic [7:0] reg_ofs; // Low address byte
  logic [31:0] verdict_word; // Verdict as software reads it

  assign acc_start = psel & penable & ~st_ff.pready;
  assign acc_done = psel & penable & st_ff.pready;
  assign reg_ofs = paddr[7:0];

  always_comb begin
    verdict_word = 32'h0000_0000;
    verdict_word[VER_CLASS_LSB +: 4] = st_ff.cls;
    verdict_word[VER_INDEX_LSB +: 6] = st_ff.idx;
    verdict_word[VER_OK_BIT] = st_ff.ok;
    verdict_word[VER_RI_BIT] = st_ff.ri;
    verdict_word[VER_CPU_BIT] = st_ff.cpu;
    verdict_word[VER_COP_LSB +: 2] = st_ff.cop;
  end

  // One wait state per transfer keeps every answer registered
  always_comb begin
    nxt_st = st_ff;
    nxt_st.vstb = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    // Owed decode: capture verdict and tally faults
    if (st_ff.pend) begin
      nxt_st.pend = 1'b0;
      nxt_st.cls = d_class;
      nxt_st.idx = d_index;
      nxt_st.ok = v_ok;
      nxt_st.ri = v_ri;
      nxt_st.cpu = v_cpu;
      nxt_st.cop = d_cop;
      nxt_st.vstb = 1'b1;
      nxt_st.ri_cnt = st_ff.ri_cnt + CNT_W'(v_ri);
      nxt_st.cpu_cnt = st_ff.cpu_cnt + CNT_W'(v_cpu);
    end
    // Answer phase: read data and error flag
    if (acc_start) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h0000_0000;
      case (reg_ofs)
        INSTR_WORD_OFS: nxt_st.prdata = st_ff.instr;
        MODE_CTRL_OFS: nxt_st.prdata = {20'h00000, st_ff.mode};
        VERDICT_OFS: nxt_st.prdata = verdict_word;
        FAULT_COUNT_OFS: begin
          nxt_st.prdata = 32'({st_ff.cpu_cnt, st_ff.ri_cnt});
        end
        default: begin
          nxt_st.pslverr = 1'b1; // Unmapped address
        end
      endcase
      if (paddr[ADDR_W-1:0] != ADDR_W'(reg_ofs)) begin
        nxt_st.pslverr = 1'b1; // Above the map
        nxt_st.prdata = 32'h0000_0000;
      end
    end
    // Writes land on the edge that completes the transfer
    if (acc_done && pwrite && !st_ff.pslverr) begin
      case (reg_ofs)
        INSTR_WORD_OFS: begin
          nxt_st.instr = pwdata;
          nxt_st.pend = 1'b1;
        end
        MODE_CTRL_OFS: begin
          nxt_st.mode = pwdata[11:0];
          nxt_st.pend = 1'b1;
        end
        FAULT_COUNT_OFS: begin
          // A fault tallied in this cycle survives the clear
          nxt_st.ri_cnt = CNT_W'(st_ff.pend & v_ri);
          nxt_st.cpu_cnt = CNT_W'(st_ff.pend & v_cpu);
        end
        default: begin
          nxt_st.pend = nxt_st.pend; // Read-only or unmapped
        end
      endcase
    end
  end

  // Reset leaves a neutral verdict and an idle bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '{instr: 32'h0000_0000, mode: MODE_RESET,
                 pend: 1'b0, cls: CLS_PRIMARY, idx: 6'h00,
                 ok: 1'b0, ri: 1'b0, cpu: 1'b0, cop: 2'd0,
                 vstb: 1'b0, ri_cnt: '0, cpu_cnt: '0,
                 pready: 1'b0, pslverr: 1'b0,
                 prdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from the state register
  // ----------------------------------------------------------------
  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign verdict_stb = st_ff.vstb;
  assign op_class = st_ff.cls;
  assign op_index = st_ff.idx;
  assign op_ok = st_ff.ok;
  assign raise_ri = st_ff.ri;
  assign raise_cpu = st_ff.cpu;
  assign cop_unit = st_ff.cop;

endmodule // cpu_instruction_decoder

//--- sim/cpu_instruction_decoder_checker.sv
// Concurrent checks on the decoder's top-level ports.
// Assumes one pclk domain with presetn as its only reset.
`timescale 1ns/1ps
module decoder_checker
  import cpu_decode_pkg::*;
#(
  parameter int ADDR_W = 8, // APB address width
  parameter int CNT_W = 16 // Fault counter width
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Verdict side
  input wire logic verdict_stb,
  input op_class_e op_class,
  input wire logic [5:0] op_index,
  input wire logic op_ok,
  input wire logic raise_ri,
  input wire logic raise_cpu,
  input wire logic [1:0] cop_unit
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic acc; // Completed transfer
  logic wr_dec; // Write that starts a decode
  logic mapped; // One of the four words
  assign acc = psel && penable && pready;
  assign mapped = paddr[ADDR_W-1:4] == '0 && paddr[1:0] == 2'b00;
  assign wr_dec = acc && pwrite && paddr[ADDR_W-1:3] == '0 &&
                  paddr[1:0] == 2'b00;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_one_outcome: assert property (verdict_stb |->
    $onehot({op_ok, raise_ri, raise_cpu}))
    else $error("verdict without exactly one outcome");
  chk_decode_follows: assert property (wr_dec |-> ##[1:2] verdict_stb)
    else $error("no verdict after word or mode write");
  chk_stb_single: assert property (verdict_stb |=> !verdict_stb)
    else $error("verdict strobe longer than one cycle");
  chk_fields_hold: assert property (!verdict_stb |->
    $stable({op_ok, raise_ri, raise_cpu, op_class, op_index}))
    else $error("verdict changed without strobe");
  chk_access_wait: assert property (psel && $rose(penable) |->
    !pready ##1 pready)
    else $error("access phase not one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over two cycles");
  chk_err_map: assert property (acc |-> pslverr == !mapped)
    else $error("error flag does not match address map");
  chk_sys_fn_set: assert property (
    verdict_stb && op_ok && op_class == CLS_SYS_FN |->
    op_index inside {6'h01, 6'h02, 6'h06, 6'h08, 6'h18, 6'h1f, 6'h20})
    else $error("system function accepted off its code set");
  chk_trap_rsv: assert property (
    verdict_stb && op_ok && op_class == CLS_FUNC |->
    !(op_index inside {6'h05, 6'h35, 6'h37}))
    else $error("reserved function code accepted");
  chk_tf_index: assert property (
    verdict_stb && op_class == CLS_COND_MOVE |-> op_index[5:1] == 5'h00)
    else $error("conditional move index beyond sense bit");
endmodule // decoder_checker

bind cpu_instruction_decoder decoder_checker #(.ADDR_W(ADDR_W),
  .CNT_W(CNT_W)) u_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .verdict_stb(verdict_stb), .op_class(op_class), .op_index(op_index),
  .op_ok(op_ok), .raise_ri(raise_ri), .raise_cpu(raise_cpu),
  .cop_unit(cop_unit));

//--- sim/cpu_instruction_decoder_tb.sv
// Self-checking bench of the decoder: table of words, then odd cases.
// Assumes the fetch model drives APB; verdict seen at the ports.
`timescale 1ns/1ps
module cpu_instruction_decoder_tb
  import cpu_decode_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn;
  logic psel, penable, pwrite, pready, pslverr, verdict_stb;
  logic op_ok, raise_ri, raise_cpu;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic err;
  op_class_e op_class;
  logic [5:0] op_index;
  logic [1:0] cop_unit;
  int mismatches = 0;
  int cmp_count = 0;

  // Word, mode, outcome {cpu,ri,ok}, and table/index when accepted
  typedef struct {
    logic [31:0] w;
    logic [11:0] m;
    logic [2:0] v;
    op_class_e c;
    logic [5:0] i;
  } row_s;
  localparam int NROWS = 37;
  row_s rows [NROWS] = '{
    '{32'h2000_0000,12'h000,3'h1,CLS_PRIMARY,6'h08},
    '{32'h7c00_0000,12'h000,3'h2,CLS_PRIMARY,6'h00},
    '{32'h0800_0000,12'h000,3'h1,CLS_PRIMARY,6'h02},
    '{32'h0000_0034,12'h000,3'h1,CLS_FUNC,6'h34},
    '{32'h0000_0036,12'h000,3'h1,CLS_FUNC,6'h36},
    '{32'h0000_0037,12'h000,3'h2,CLS_PRIMARY,6'h00},
    '{32'h0408_0000,12'h000,3'h1,CLS_REG_IMMEDIATE_CLASS,6'h08},
    '{32'h041f_0000,12'h000,3'h2,CLS_PRIMARY,6'h00},
    '{32'h6000_0000,12'h000,3'h2,CLS_PRIMARY,6'h00},
    '{32'h6000_0000,12'h004,3'h1,CLS_PRIMARY,6'h18},
    '{32'h6000_0000,12'h002,3'h1,CLS_PRIMARY,6'h18},
    '{32'h7400_0000,12'h000,3'h2,CLS_PRIMARY,6'h00},
    '{32'h7400_0000,12'h008,3'h1,CLS_PRIMARY,6'h1d},
    '{32'h7000_003f,12'h000,3'h2,CLS_PRIMARY,6'h00},
    '{32'h7000_003f,12'h010,3'h1,CLS_SECOND,6'h3f},
    '{32'h7000_0003,12'h000,3'h2,CLS_PRIMARY,6'h00},
    '{32'h7000_0020,12'h000,3'h1,CLS_SECOND,6'h20},
    '{32'h4000_0000,12'h000,3'h4,CLS_PRIMARY,6'h00},
    '{32'h4000_0000,12'h001,3'h1,CLS_COP_MOVE,6'h00},
    '{32'h4040_0000,12'h001,3'h2,CLS_PRIMARY,6'h00},
    '{32'h4200_0001,12'h001,3'h1,CLS_SYS_FN,6'h01},
    '{32'h4200_0018,12'h001,3'h1,CLS_SYS_FN,6'h18},
    '{32'h4200_0003,12'h001,3'h2,CLS_PRIMARY,6'h00},
    '{32'h4440_0000,12'h200,3'h1,CLS_COP_MOVE,6'h02},
    '{32'h4800_0000,12'h000,3'h4,CLS_PRIMARY,6'h00},
    '{32'h4a00_0000,12'h400,3'h2,CLS_PRIMARY,6'h00},
    '{32'h0001_0001,12'h200,3'h1,CLS_COND_MOVE,6'h01},
    '{32'h4503_0000,12'h200,3'h1,CLS_COP_BRANCH,6'h03},
    '{32'h4600_0000,12'h200,3'h1,CLS_FP_SINGLE,6'h00},
    '{32'h4600_0008,12'h200,3'h2,CLS_PRIMARY,6'h00},
    '{32'h4600_0037,12'h200,3'h1,CLS_FP_SINGLE,6'h37},
    '{32'h46a0_0000,12'h200,3'h2,CLS_PRIMARY,6'h00},
    '{32'h4620_0000,12'h200,3'h1,CLS_FP_FMT,6'h00},
    '{32'h4c00_0000,12'h200,3'h2,CLS_PRIMARY,6'h00},
    '{32'h4520_0000,12'h200,3'h2,CLS_PRIMARY,6'h00},
    '{32'h0000_001d,12'h004,3'h1,CLS_FUNC,6'h1d},
    '{32'h5000_0000,12'h000,3'h1,CLS_PRIMARY,6'h14}
  };

  // ----------------------------------------
  // Clock, parts
  // ----------------------------------------
  initial begin
    forever #25 pclk = ~pclk;
  end

  fetch_stage_model fetch (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  cpu_instruction_decoder DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .verdict_stb(verdict_stb), .op_class(op_class), .op_index(op_index),
    .op_ok(op_ok), .raise_ri(raise_ri), .raise_cpu(raise_cpu),
    .cop_unit(cop_unit));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    fetch.xfer(1'b1, a, d, r, e);
  endtask

  // Mode then word, then wait a bounded time for the strobe
  task automatic dec(input logic [31:0] w, input logic [11:0] m);
    int n;
    n = 0;
    wr(MODE_CTRL_OFS, {20'h0, m});
    wr(INSTR_WORD_OFS, w);
    do begin
      @(posedge pclk);
      n++;
    end while (verdict_stb !== 1'b1 && n < 4);
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog: the whole run needs well under 2000 cycles
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    chk({29'h0, raise_cpu, raise_ri, op_ok}, 32'h0);
    presetn <= 1'b1;
    fetch.xfer(1'b0, MODE_CTRL_OFS, 32'h0, rdat, err);
    chk(rdat, 32'h0);
    foreach (rows[k]) begin
      dec(rows[k].w, rows[k].m);
      chk({31'h0, verdict_stb}, 32'h1);
      chk({29'h0, raise_cpu, raise_ri, op_ok}, {29'h0, rows[k].v});
      if (rows[k].v == 3'h1) begin
        chk({22'h0, op_class, op_index}, {22'h0, rows[k].c, rows[k].i});
      end
    end
    // Unmapped place: error, zero data
    fetch.xfer(1'b0, 8'h10, 32'h0, rdat, err);
    chk({31'h0, err}, 32'h1);
    chk(rdat, 32'h0);
    // Read-only verdict keeps the last outcome despite a write
    wr(VERDICT_OFS, 32'hffff_ffff);
    fetch.xfer(1'b0, VERDICT_OFS, 32'h0, rdat, err);
    chk({29'h0, rdat[14:12]}, {29'h0, rows[NROWS-1].v});
    // Fault tallies: cleared, then one of each kind
    wr(MODE_CTRL_OFS, 32'h0);
    wr(FAULT_COUNT_OFS, 32'h0);
    wr(INSTR_WORD_OFS, 32'hfc00_0000);
    wr(INSTR_WORD_OFS, 32'h4000_0000);
    fetch.xfer(1'b0, FAULT_COUNT_OFS, 32'h0, rdat, err);
    chk(rdat, 32'h0001_0001);
    // Partner load on a usable unit: RI, unit named
    dec(32'hc800_0000, 12'h400);
    chk({27'h0, raise_cpu, raise_ri, op_ok, cop_unit}, 32'h0a);
    // Reset in mid-run clears the verdict
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({29'h0, raise_cpu, raise_ri, op_ok}, 32'h0);
    close_out();
  end
endmodule // cpu_instruction_decoder_tb

//--- sim/fetch_stage_model.sv
// Fetch-side model: drives APB transfers into the decoder.
// Assumes pclk from the bench; the slave answers with pready.
`timescale 1ns/1ps
module fetch_stage_model (
  // Clock
  input wire logic pclk,
  // Request towards the decoder
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer from the decoder
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------
  // Idle bus at time zero
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // ----------------------------------------
  // One transfer; a word or mode goes out whole
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; a dead slave is the watchdog's
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    // Released lines must not keep the stale value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // fetch_stage_model
